// ### core/sync_params.svh
/*
 * Constants of the multi-module sync controller: timing figures, reset
 * values, subsystem indexes and pin positions of the sampled inputs.
 * Assumes a 200 MHz core clock and a 48 MHz reference arriving on a pin.
 */
// Functional notes
// [R1] Input and output subsystems each pick sync mode
// [R2] Master drives trigger and clock onto link
// [R3] Slave uses link clock, link trigger starts
// [R4] None mode: ignore link, use 48 MHz reference
// [R5] Mode holds until rewritten or session ends
// [R6] Master/slave mix on one device flags error
// [R7] Output subsystem clock comes from input link
// [R8] Master and armed slaves start within one conversion
// [R9] Reference trigger starts post-trigger scan count everywhere
// [R10] Software arms slaves before starting master
// [R11] Aborting a waiting slave takes about 20 s
// [R12] No reference trigger: master stop leaves slaves running
// [R13] Inputs align with inputs, outputs with outputs
// [R14] Trigger launched and sampled on shared clock edge
`ifndef SYNC_PARAMS_SVH
`define SYNC_PARAMS_SVH

`define CLK_FREQ_MHZ 200
`define REF_FREQ_MHZ 48
`define STOP_WAIT_S 20
`define STOP_WAIT_CYCLES (64'd`STOP_WAIT_S * 64'd`CLK_FREQ_MHZ * 64'd1000000)
`define CONV_DIV_DEFAULT 48
`define POST_W 16
`define MODE_RESET 2'h0

`define SUB_AIN 0
`define SUB_AOUT 1

`define PIN_REF 0
`define PIN_AIN_CLK 1
`define PIN_AIN_TRIG 2
`define PIN_AOUT_TRIG 3
`define PIN_EXT_REF 4
`define PIN_COUNT 5

`endif

// ### core/sync_pkg.sv
/*
 * Types shared by the sync controller modules: modes, sequencer states
 * and the sequencer state record.
 * Assumes sync_params.svh is on the include path.
 */
`include "sync_params.svh"

package sync_pkg;

   typedef enum logic [1:0] {
      MODE_NONE = 2'h0,
      MODE_MASTER = 2'h1,
      MODE_SLAVE = 2'h2
   } sync_mode_e;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ARMED = 5'h02,
      ST_RUN = 5'h04,
      ST_POST = 5'h08,
      ST_STOP = 5'h10
   } seq_state_e;

   typedef struct packed {
      seq_state_e st;
      logic [31:0] wait_cnt;
      logic [`POST_W-1:0] post_cnt;
      logic pend;
      logic trig_q;
      logic run;
      logic sample;
      logic done;
      logic stop_ack;
      logic trig_out;
   } seq_s;

endpackage : sync_pkg

// ### core/link_sampler.sv
/*
 * Two-stage synchroniser for a group of pins from outside the core clock.
 * Assumes each pin holds a level for at least two core clock periods.
 */
`timescale 1ns/1ps

module link_sampler #(
   parameter int W = 1
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] pins_i,
   output logic [W-1:0] sync_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } smp_s;

   smp_s s_ff;
   smp_s nxt_s;

   // First stage feeds only the second stage
   always_comb begin
      nxt_s = s_ff;
      nxt_s.meta = pins_i;
      nxt_s.sync = s_ff.meta;
   end

   // Frozen while the clock enable is low
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         s_ff <= '0;
      end else if (ce_i) begin
         s_ff <= nxt_s;
      end
   end

   assign sync_o = s_ff.sync;

endmodule : link_sampler

// ### core/subsys_seq.sv
/*
 * Arm / start / run / post-trigger / stop sequencer of one converter
 * subsystem. Assumes tick_i is a one-cycle conversion strobe already chosen
 * for the mode, and link_trig_i is a synchronised link level.
 */
`timescale 1ns/1ps

module subsys_seq
   import sync_pkg::*;
#(
   parameter logic [31:0] STOP_WAIT = 32'(`STOP_WAIT_CYCLES)
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire sync_mode_e mode_i,
   input wire logic arm_i,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic ref_en_i,
   input wire logic ref_trig_i,
   input wire logic [`POST_W-1:0] post_count_i,
   input wire logic tick_i,
   input wire logic link_trig_i,
   output logic run_o,
   output logic sample_o,
   output logic done_o,
   output logic stop_ack_o,
   output logic trig_out_o
);

   seq_s s_ff;
   seq_s nxt_s;
   logic slave;
   logic link_rise;
   logic link_fall;

   // Link trigger edges, seen only on the shared conversion edge
   assign slave = (mode_i == MODE_SLAVE);
   assign link_rise = tick_i && link_trig_i && !s_ff.trig_q; // R14
   assign link_fall = tick_i && !link_trig_i && s_ff.trig_q;

   // Sequencer
   always_comb begin
      nxt_s = s_ff;
      nxt_s.sample = 1'b0;
      nxt_s.done = 1'b0;
      nxt_s.stop_ack = 1'b0;
      if (tick_i) begin
         nxt_s.trig_q = link_trig_i; // R14
      end
      case (s_ff.st)
         ST_IDLE: begin
            nxt_s.pend = 1'b0;
            if (arm_i) begin
               nxt_s.st = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (stop_i && slave) begin
               nxt_s.st = ST_STOP; // R11
               nxt_s.wait_cnt = STOP_WAIT - 32'h1;
            end else if (stop_i) begin
               nxt_s.st = ST_IDLE;
               nxt_s.stop_ack = 1'b1;
            end else if (slave) begin
               if (link_rise) begin
                  nxt_s.st = ST_RUN; // R3
                  nxt_s.run = 1'b1;
               end
            end else begin
               if (start_i) begin
                  nxt_s.pend = 1'b1;
               end
               if ((start_i || s_ff.pend) && tick_i) begin
                  nxt_s.st = ST_RUN; // R8
                  nxt_s.run = 1'b1;
                  nxt_s.trig_out = (mode_i == MODE_MASTER); // R2
               end
            end
         end
         ST_RUN: begin
            nxt_s.sample = tick_i;
            if (stop_i) begin
               nxt_s.st = ST_IDLE; // R12
               nxt_s.run = 1'b0;
               nxt_s.trig_out = 1'b0;
               nxt_s.stop_ack = 1'b1;
            end else if (ref_en_i && (slave ? link_fall : ref_trig_i)) begin
               nxt_s.st = ST_POST; // R9
               nxt_s.post_cnt = post_count_i;
               nxt_s.trig_out = 1'b0;
            end
         end
         ST_POST: begin
            nxt_s.sample = tick_i;
            if (stop_i) begin
               nxt_s.st = ST_IDLE;
               nxt_s.run = 1'b0;
               nxt_s.stop_ack = 1'b1;
            end else if (tick_i) begin
               if (s_ff.post_cnt <= `POST_W'(1)) begin
                  nxt_s.st = ST_IDLE; // R9
                  nxt_s.run = 1'b0;
                  nxt_s.done = 1'b1;
               end else begin
                  nxt_s.post_cnt = s_ff.post_cnt - `POST_W'(1);
               end
            end
         end
         ST_STOP: begin
            if (s_ff.wait_cnt == 32'h0) begin
               nxt_s.st = ST_IDLE; // R11
               nxt_s.stop_ack = 1'b1;
            end else begin
               nxt_s.wait_cnt = s_ff.wait_cnt - 32'h1;
            end
         end
         default: begin
            nxt_s.st = ST_IDLE;
         end
      endcase
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         s_ff <= '{st: ST_IDLE, default: '0};
      end else if (ce_i) begin
         s_ff <= nxt_s;
      end
   end

   assign run_o = s_ff.run;
   assign sample_o = s_ff.sample;
   assign done_o = s_ff.done;
   assign stop_ack_o = s_ff.stop_ack;
   assign trig_out_o = s_ff.trig_out;

   // A waiting slave starts on the link edge and only on it
   property p_slave_start;
      @(posedge clock_i) disable iff (srst_i)
      ce_i && s_ff.st == ST_ARMED && slave && !stop_i && link_rise
      |=> s_ff.st == ST_RUN && s_ff.run;
   endproperty
   a_slave_start: assert property (p_slave_start) // R3
      else $error("slave did not start on link trigger");

   property p_slave_ignores_local;
      @(posedge clock_i) disable iff (srst_i)
      ce_i && s_ff.st == ST_ARMED && slave && !link_rise
      |=> s_ff.st != ST_RUN;
   endproperty
   a_slave_ignores_local: assert property (p_slave_ignores_local) // R3
      else $error("slave started without link trigger");

   // Abort of a waiting slave enters the long wait with no early answer
   property p_slow_abort;
      @(posedge clock_i) disable iff (srst_i)
      ce_i && s_ff.st == ST_ARMED && slave && stop_i
      |=> s_ff.st == ST_STOP && !s_ff.stop_ack;
   endproperty
   a_slow_abort: assert property (p_slow_abort) // R11
      else $error("slave abort did not enter stop wait");

   property p_no_early_ack;
      @(posedge clock_i) disable iff (srst_i)
      s_ff.st == ST_STOP && s_ff.wait_cnt != 32'h0 |=> !s_ff.stop_ack;
   endproperty
   a_no_early_ack: assert property (p_no_early_ack) // R11
      else $error("stop acknowledged before wait elapsed");

   // Slaves run on through a master stop unless a reference trigger is used
   property p_slave_keeps_running;
      @(posedge clock_i) disable iff (srst_i)
      ce_i && s_ff.st == ST_RUN && slave && !ref_en_i && !stop_i
      |=> s_ff.st == ST_RUN;
   endproperty
   a_slave_keeps_running: assert property (p_slave_keeps_running) // R12
      else $error("slave left run without its own stop");

   property p_post_count;
      @(posedge clock_i) disable iff (srst_i)
      ce_i && s_ff.st == ST_POST && tick_i && !stop_i
      && s_ff.post_cnt > `POST_W'(1)
      |=> s_ff.post_cnt == $past(s_ff.post_cnt) - `POST_W'(1);
   endproperty
   a_post_count: assert property (p_post_count) // R9
      else $error("post-trigger count did not step");

endmodule : subsys_seq

// ### core/multi_module_sync_controller.sv
/*
 * Top of the multi-module sync controller: per-subsystem mode holding and
 * mix check, conversion timing from the local reference or the link, link
 * pin drive, and two subsystem sequencers (input and output side).
 * Assumes link and reference pins are asynchronous to clock_i, that
 * control strobes are one-cycle pulses on clock_i, and that the output
 * subsystem's link carries only a trigger; its clock is the input link's.
 */
`timescale 1ns/1ps

module multi_module_sync_controller
   import sync_pkg::*;
#(
   parameter int CONV_DIV = `CONV_DIV_DEFAULT,
   parameter logic [31:0] STOP_WAIT = 32'(`STOP_WAIT_CYCLES)
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Mode programming
   input wire sync_mode_e ain_mode_i,
   input wire sync_mode_e aout_mode_i,
   input wire logic mode_wr_i,
   input wire logic session_end_i,
   // Per subsystem control, bit 0 input side, bit 1 output side
   input wire logic [1:0] arm_i,
   input wire logic [1:0] start_i,
   input wire logic [1:0] stop_i,
   input wire logic [1:0] ref_en_i,
   input wire logic [`POST_W-1:0] ain_post_count_i,
   input wire logic [`POST_W-1:0] aout_post_count_i,
   // Local reference and reference trigger sources
   input wire logic ref_clk_i,
   input wire logic ext_ref_trig_i,
   input wire logic [1:0] thresh_det_i,
   // Input-side link connector
   input wire logic ain_link_clk_i,
   output logic ain_link_clk_o,
   output logic ain_link_clk_oe_o,
   input wire logic ain_link_trig_i,
   output logic ain_link_trig_o,
   output logic ain_link_trig_oe_o,
   // Output-side link connector
   input wire logic output_sync_connector_trig_i,
   output logic output_sync_connector_trig_o,
   output logic output_sync_connector_trig_oe_o,
   // Status
   output logic mode_err_o,
   output logic [1:0] run_o,
   output logic [1:0] sample_o,
   output logic [1:0] done_o,
   output logic [1:0] stop_ack_o
);

   localparam logic [7:0] DIV_LAST = 8'(CONV_DIV - 1);

   typedef struct packed {
      sync_mode_e ain_mode;
      sync_mode_e aout_mode;
      logic mode_err;
      logic [7:0] div_cnt;
      logic ref_q;
      logic ext_q;
      logic link_clk_q;
      logic link_clk_out;
      logic clk_oe;
      logic ain_trig_oe;
      logic aout_trig_oe;
   } top_s;

   top_s s_ff;
   top_s nxt_s;
   logic [`PIN_COUNT-1:0] pins;
   logic [`PIN_COUNT-1:0] pins_sync;
   logic ref_rise;
   logic ext_rise;
   logic link_clk_rise;
   logic local_tick;
   logic master_tick;
   logic any_master;
   logic new_mix;
   sync_mode_e mode [2];
   logic [1:0] tick;
   logic [1:0] link_trig;
   logic [1:0] ref_trig;
   logic [1:0] trig_out;
   logic [`POST_W-1:0] post_count [2];

   // All pins from outside the clock domain pass two flip-flops
   assign pins[`PIN_REF] = ref_clk_i;
   assign pins[`PIN_AIN_CLK] = ain_link_clk_i;
   assign pins[`PIN_AIN_TRIG] = ain_link_trig_i;
   assign pins[`PIN_AOUT_TRIG] = output_sync_connector_trig_i;
   assign pins[`PIN_EXT_REF] = ext_ref_trig_i;

   link_sampler #(
      .W(`PIN_COUNT)
   ) u_sampler (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .pins_i(pins),
      .sync_o(pins_sync)
   );

   // Edges of the synchronised pins, against a copy held in the state
   assign ref_rise = pins_sync[`PIN_REF] && !s_ff.ref_q;
   assign ext_rise = pins_sync[`PIN_EXT_REF] && !s_ff.ext_q;
   assign link_clk_rise = pins_sync[`PIN_AIN_CLK] && !s_ff.link_clk_q;

   // Local conversion tick derived from the 48 MHz reference
   assign local_tick = ref_rise && (s_ff.div_cnt == DIV_LAST); // R4
   // A master converts on the rising edge of the clock it drives out
   assign master_tick = local_tick && !s_ff.link_clk_out; // R14
   assign any_master = (s_ff.ain_mode == MODE_MASTER)
                       || (s_ff.aout_mode == MODE_MASTER);
   assign new_mix = ((ain_mode_i == MODE_MASTER)
                     && (aout_mode_i == MODE_SLAVE))
                    || ((ain_mode_i == MODE_SLAVE)
                        && (aout_mode_i == MODE_MASTER));

   // Mode holding, error flag, divider and link pin drive
   always_comb begin
      nxt_s = s_ff;
      nxt_s.ref_q = pins_sync[`PIN_REF];
      nxt_s.ext_q = pins_sync[`PIN_EXT_REF];
      nxt_s.link_clk_q = pins_sync[`PIN_AIN_CLK];
      if (session_end_i) begin
         nxt_s.ain_mode = MODE_NONE; // R5
         nxt_s.aout_mode = MODE_NONE;
         nxt_s.mode_err = 1'b0;
      end else if (mode_wr_i) begin
         if (new_mix) begin
            nxt_s.mode_err = 1'b1; // R6
         end else begin
            nxt_s.ain_mode = ain_mode_i; // R1
            nxt_s.aout_mode = aout_mode_i;
            nxt_s.mode_err = 1'b0;
         end
      end
      if (ref_rise) begin
         if (s_ff.div_cnt == DIV_LAST) begin
            nxt_s.div_cnt = 8'h00;
         end else begin
            nxt_s.div_cnt = s_ff.div_cnt + 8'h01;
         end
      end
      if (local_tick && any_master) begin
         nxt_s.link_clk_out = !s_ff.link_clk_out; // R2
      end else if (!any_master) begin
         nxt_s.link_clk_out = 1'b0;
      end
      // Either master subsystem drives the shared clock
      nxt_s.clk_oe = (nxt_s.ain_mode == MODE_MASTER)
                     || (nxt_s.aout_mode == MODE_MASTER); // R2
      nxt_s.ain_trig_oe = (nxt_s.ain_mode == MODE_MASTER);
      nxt_s.aout_trig_oe = (nxt_s.aout_mode == MODE_MASTER);
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         s_ff <= '{ain_mode: MODE_NONE, aout_mode: MODE_NONE, default: '0};
      end else if (ce_i) begin
         s_ff <= nxt_s;
      end
   end

   // Per subsystem wiring; each side listens only to its own trigger line
   assign mode[`SUB_AIN] = s_ff.ain_mode;
   assign mode[`SUB_AOUT] = s_ff.aout_mode;
   assign link_trig[`SUB_AIN] = pins_sync[`PIN_AIN_TRIG]; // R13
   assign link_trig[`SUB_AOUT] = pins_sync[`PIN_AOUT_TRIG]; // R13
   assign post_count[`SUB_AIN] = ain_post_count_i;
   assign post_count[`SUB_AOUT] = aout_post_count_i;

   // Two sequencers; both slaves take their clock from the input link
   for (genvar i = 0; i < 2; i++) begin : g_sub
      always_comb begin
         if (mode[i] == MODE_SLAVE) begin
            tick[i] = link_clk_rise; // R7
         end else if (mode[i] == MODE_MASTER) begin
            tick[i] = master_tick;
         end else begin
            tick[i] = local_tick; // R4
         end
      end

      // Master reference trigger: external pin edge or threshold hit
      assign ref_trig[i] = ext_rise || thresh_det_i[i]; // R9

      subsys_seq #(
         .STOP_WAIT(STOP_WAIT)
      ) u_seq (
         .clock_i(clock_i),
         .srst_i(srst_i),
         .ce_i(ce_i),
         .mode_i(mode[i]),
         .arm_i(arm_i[i]),
         .start_i(start_i[i]),
         .stop_i(stop_i[i]),
         .ref_en_i(ref_en_i[i]),
         .ref_trig_i(ref_trig[i]),
         .post_count_i(post_count[i]),
         .tick_i(tick[i]),
         .link_trig_i(link_trig[i]),
         .run_o(run_o[i]),
         .sample_o(sample_o[i]),
         .done_o(done_o[i]),
         .stop_ack_o(stop_ack_o[i]),
         .trig_out_o(trig_out[i])
      );
   end

   // Link pins come straight from flip-flops
   assign ain_link_clk_o = s_ff.link_clk_out;
   assign ain_link_clk_oe_o = s_ff.clk_oe;
   assign ain_link_trig_o = trig_out[`SUB_AIN];
   assign ain_link_trig_oe_o = s_ff.ain_trig_oe;
   assign output_sync_connector_trig_o = trig_out[`SUB_AOUT];
   assign output_sync_connector_trig_oe_o = s_ff.aout_trig_oe;
   assign mode_err_o = s_ff.mode_err;

   // A mixed write is refused and flagged, the old modes stay
   property p_mix_refused;
      @(posedge clock_i) disable iff (srst_i)
      ce_i && mode_wr_i && !session_end_i && new_mix
      |=> mode_err_o && $stable(s_ff.ain_mode) && $stable(s_ff.aout_mode);
   endproperty
   a_mix_refused: assert property (p_mix_refused) // R6
      else $error("master/slave mix not refused");

   property p_modes_independent;
      @(posedge clock_i) disable iff (srst_i)
      ce_i && mode_wr_i && !session_end_i && !new_mix
      |=> s_ff.ain_mode == $past(ain_mode_i)
          && s_ff.aout_mode == $past(aout_mode_i) && !mode_err_o;
   endproperty
   a_modes_independent: assert property (p_modes_independent) // R1
      else $error("mode write not applied");

   property p_mode_holds;
      @(posedge clock_i) disable iff (srst_i)
      !mode_wr_i && !session_end_i
      |=> $stable(s_ff.ain_mode) && $stable(s_ff.aout_mode);
   endproperty
   a_mode_holds: assert property (p_mode_holds) // R5
      else $error("mode changed without a write");

   property p_session_end;
      @(posedge clock_i) disable iff (srst_i)
      ce_i && session_end_i
      |=> s_ff.ain_mode == MODE_NONE && s_ff.aout_mode == MODE_NONE;
   endproperty
   a_session_end: assert property (p_session_end) // R5
      else $error("session end did not restore none mode");

   // Outside master mode nothing drives the link
   property p_none_quiet;
      @(posedge clock_i) disable iff (srst_i)
      ce_i && !mode_wr_i && !any_master
      |=> !ain_link_clk_oe_o && !ain_link_trig_oe_o
          && !output_sync_connector_trig_oe_o;
   endproperty
   a_none_quiet: assert property (p_none_quiet) // R4
      else $error("link driven outside master mode");

   property p_master_drives;
      @(posedge clock_i) disable iff (srst_i)
      ce_i && !mode_wr_i && !session_end_i && s_ff.ain_mode == MODE_MASTER
      |=> ain_link_clk_oe_o && ain_link_trig_oe_o;
   endproperty
   a_master_drives: assert property (p_master_drives) // R2
      else $error("input master not driving link");

   // Master clock edge on the link marks the master's own conversion
   property p_master_tick_edge;
      @(posedge clock_i) disable iff (srst_i)
      ce_i && master_tick && any_master |=> ain_link_clk_o;
   endproperty
   a_master_tick_edge: assert property (p_master_tick_edge) // R14
      else $error("master tick not on rising link clock");

   property p_out_slave_clock;
      @(posedge clock_i) disable iff (srst_i)
      ce_i && s_ff.aout_mode == MODE_SLAVE && !link_clk_rise
      |=> !sample_o[`SUB_AOUT];
   endproperty
   a_out_slave_clock: assert property (p_out_slave_clock) // R7
      else $error("output slave not timed from input link clock");

endmodule : multi_module_sync_controller

// ### tb/peer_link.sv
/*
 * Peer master module on the sync link: link clock and trigger levels.
 * Assumes the bench raises active_i for a frame and sets trig_i.
 */
`timescale 1ns/1ps

module peer_link (
   input wire logic active_i,
   input wire logic trig_i,
   input wire logic dut_clk_i,
   input wire logic dut_clk_oe_i,
   input wire logic dut_trig_i,
   input wire logic dut_trig_oe_i,
   input wire logic dut_otrig_i,
   input wire logic dut_otrig_oe_i,
   output logic clk_line_o,
   output logic trig_line_o,
   output logic otrig_line_o
);
   logic clk_ff = 1'b0;
   logic trig_ff = 1'b0;
   // Link clock of 80 ns, stands still outside a frame
   always begin
      #40;
      if (active_i) clk_ff = ~clk_ff;
   end
   // Trigger moves on the falling clock, taken on the rising one
   always @(negedge clk_ff) trig_ff <= trig_i;
   // Released lines show the peer's level in a frame, the inverse of its last level outside one
   assign clk_line_o = dut_clk_oe_i ? dut_clk_i :
      (active_i ? clk_ff : ~clk_ff);
   assign trig_line_o = dut_trig_oe_i ? dut_trig_i :
      (active_i ? trig_ff : ~trig_ff);
   assign otrig_line_o = dut_otrig_oe_i ? dut_otrig_i :
      (active_i ? trig_ff : ~trig_ff);
endmodule : peer_link

// ### tb/multi_module_sync_controller_tb.sv
/*
 * Self-checking bench of the sync controller with a peer on the link.
 * Assumes short CONV_DIV and STOP_WAIT values for a quick run.
 */
`timescale 1ns/1ps
`include "sync_params.svh"

module multi_module_sync_controller_tb
   import sync_pkg::*;
;
   localparam int SW = 50;
   logic clock_i = 1'b0;
   logic srst_i = 1'b1;
   logic ce_i = 1'b1;
   sync_mode_e ain_mode_i = MODE_NONE;
   sync_mode_e aout_mode_i = MODE_NONE;
   logic mode_wr_i = 1'b0;
   logic session_end_i = 1'b0;
   logic [1:0] arm_i = 2'h0, start_i = 2'h0, stop_i = 2'h0;
   logic [1:0] ref_en_i = 2'h0, thresh_det_i = 2'h0;
   logic [`POST_W-1:0] ain_post_count_i = 16'h0003;
   logic [`POST_W-1:0] aout_post_count_i = 16'h0003;
   logic ref_clk_i = 1'b0, ext_ref_trig_i = 1'b0;
   logic peer_act = 1'b0, peer_trig = 1'b0;
   logic ain_link_clk_i, ain_link_trig_i, output_sync_connector_trig_i;
   logic ain_link_clk_o, ain_link_clk_oe_o, ain_link_trig_o;
   logic ain_link_trig_oe_o, mode_err_o;
   logic output_sync_connector_trig_o, output_sync_connector_trig_oe_o;
   logic [1:0] run_o, sample_o, done_o, stop_ack_o;
   int n_fail = 0;
   int n_checks = 0;

   // Core clock and the local 48 MHz reference
   always #2.5 clock_i = ~clock_i;
   always #10.417 ref_clk_i = ~ref_clk_i;

   multi_module_sync_controller #(.CONV_DIV(2), .STOP_WAIT(32'(SW))) i_dut (
      .clock_i, .srst_i, .ce_i, .ain_mode_i, .aout_mode_i, .mode_wr_i,
      .session_end_i, .arm_i, .start_i, .stop_i, .ref_en_i,
      .ain_post_count_i, .aout_post_count_i, .ref_clk_i, .ext_ref_trig_i,
      .thresh_det_i, .ain_link_clk_i, .ain_link_clk_o, .ain_link_clk_oe_o,
      .ain_link_trig_i, .ain_link_trig_o, .ain_link_trig_oe_o,
      .output_sync_connector_trig_i, .output_sync_connector_trig_o,
      .output_sync_connector_trig_oe_o, .mode_err_o, .run_o, .sample_o,
      .done_o, .stop_ack_o);

   peer_link i_peer (.active_i(peer_act), .trig_i(peer_trig),
      .dut_clk_i(ain_link_clk_o), .dut_clk_oe_i(ain_link_clk_oe_o),
      .dut_trig_i(ain_link_trig_o), .dut_trig_oe_i(ain_link_trig_oe_o),
      .dut_otrig_i(output_sync_connector_trig_o),
      .dut_otrig_oe_i(output_sync_connector_trig_oe_o),
      .clk_line_o(ain_link_clk_i), .trig_line_o(ain_link_trig_i),
      .otrig_line_o(output_sync_connector_trig_i));

   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   // One-cycle strobe: 0 arm, 1 start, 2 stop, 3 threshold, 4 session end
   task automatic pulse(input int k, input int s);
      @(posedge clock_i);
      case (k)
         0: arm_i[s] <= 1'b1;
         1: start_i[s] <= 1'b1;
         2: stop_i[s] <= 1'b1;
         3: thresh_det_i[s] <= 1'b1;
         default: session_end_i <= 1'b1;
      endcase
      @(posedge clock_i);
      {arm_i, start_i, stop_i, thresh_det_i} <= 8'h00;
      session_end_i <= 1'b0;
      #1;
   endtask : pulse

   task automatic wr_mode(input sync_mode_e a, input sync_mode_e b);
      @(posedge clock_i);
      ain_mode_i <= a;
      aout_mode_i <= b;
      mode_wr_i <= 1'b1;
      @(posedge clock_i);
      mode_wr_i <= 1'b0;
      #1;
   endtask : wr_mode

   task automatic wait_run(input int s, input logic v);
      int i;
      for (i = 0; i < 2000 && run_o[s] !== v; i++) begin
         @(posedge clock_i);
         #1;
      end
      if (i == 2000) begin
         n_fail++;
         give_verdict();
      end
   endtask : wait_run

   task automatic t_modes;
      chk("clk oe", ain_link_clk_oe_o, 0);
      chk("mode err", mode_err_o, 0);
      wr_mode(MODE_MASTER, MODE_NONE);
      chk("clk oe", ain_link_clk_oe_o, 1);
      chk("trig oe", ain_link_trig_oe_o, 1);
      chk("out oe", output_sync_connector_trig_oe_o, 0);
      wr_mode(MODE_NONE, MODE_MASTER);
      chk("out oe", output_sync_connector_trig_oe_o, 1);
      chk("clk oe", ain_link_clk_oe_o, 1);
      wr_mode(MODE_MASTER, MODE_SLAVE);
      chk("mode err", mode_err_o, 1);
      chk("out oe", output_sync_connector_trig_oe_o, 1);
      pulse(4, 0);
      chk("out oe", output_sync_connector_trig_oe_o, 0);
      chk("mode err", mode_err_o, 0);
      $display("test modes done");
   endtask : t_modes

   task automatic t_master;
      wr_mode(MODE_MASTER, MODE_NONE);
      pulse(0, 0);
      pulse(1, 0);
      wait_run(0, 1'b1);
      chk("link trig", ain_link_trig_o, 1);
      pulse(2, 0);
      chk("stop ack", stop_ack_o[0], 1);
      chk("run", run_o[0], 0);
      $display("test master done");
   endtask : t_master

   task automatic t_slave(input int s);
      // Peer drives quiet lines before our link pins are released
      @(posedge clock_i) peer_act <= 1'b1;
      if (s == 1) wr_mode(MODE_NONE, MODE_SLAVE);
      else wr_mode(MODE_SLAVE, MODE_NONE);
      pulse(0, s);
      pulse(1, s);
      repeat (40) @(posedge clock_i);
      #1;
      chk("slave idle", run_o[s], 0);
      peer_trig <= 1'b1;
      wait_run(s, 1'b1);
      chk("slave run", run_o[s], 1);
      peer_trig <= 1'b0;
      repeat (200) @(posedge clock_i);
      #1;
      chk("slave kept", run_o[s], 1);
      pulse(2, s);
      chk("slave ack", stop_ack_o[s], 1);
      peer_act <= 1'b0;
      $display("test slave %0d done", s);
   endtask : t_slave

   task automatic t_abort;
      int i;
      wr_mode(MODE_SLAVE, MODE_NONE);
      pulse(0, 0);
      pulse(2, 0);
      for (i = 0; i < 200 && stop_ack_o[0] !== 1'b1; i++) begin
         @(posedge clock_i);
         #1;
      end
      chk("abort wait", 32'(i >= SW - 2 && i <= SW + 2), 1);
      $display("test abort done");
   endtask : t_abort

   task automatic t_ref;
      int i;
      int n;
      n = 0;
      wr_mode(MODE_MASTER, MODE_NONE);
      ref_en_i <= 2'h1;
      pulse(0, 0);
      pulse(1, 0);
      wait_run(0, 1'b1);
      pulse(3, 0);
      for (i = 0; i < 2000 && done_o[0] !== 1'b1; i++) begin
         @(posedge clock_i);
         #1;
         if (sample_o[0] === 1'b1) n++;
      end
      chk("post done", 32'(i < 2000), 1);
      chk("post scans", n, 3);
      chk("run", run_o[0], 0);
      chk("link trig", ain_link_trig_o, 0);
      ref_en_i <= 2'h0;
      $display("test reference done");
   endtask : t_ref

   // Main sequence
   initial begin
      repeat (4) @(posedge clock_i);
      srst_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      #1;
      t_modes();
      t_master();
      t_slave(0);
      t_slave(1);
      t_abort();
      t_ref();
      give_verdict();
   end
endmodule : multi_module_sync_controller_tb
